/* File: t2cr_regs.vh */
// Notes on behaviour
// (R1) Overflow sets overflow_flag unless a serial clock select bit is set.
// (R2) Trigger-caused capture or reload sets external_event_flag; software clears.
// (R3) Receive clock select routes this overflow to serial receive, modes 1 and 3.
// (R4) Transmit clock select routes this overflow to serial transmit, modes 1, 3.
// (R5) Trigger falling edge acts only when enabled and not clocking serial port.
// (R6) Counter runs while run_control is set; otherwise it stops counting but trigger reloads still load it.
// (R7) function_select set counts count pin edges, clear counts core clocks.
// (R8) capture_select with trigger enable captures count on trigger falling edge.
// (R9) capture_select clear reloads on overflow and on enabled trigger edges.
// (R10) Either serial clock select forces auto-reload, capture_select ignored.
// (R11) Count and capture/reload byte pairs, eight bits each, reset to zero.
// (R12) Capture copies count into reload pair; reload loads count from it.
// (R13) Count is 16 bits, low byte first; overflow is a tick at all ones, wrapping to zero only in capture mode.
`ifndef T2CR_REGS_VH
`define T2CR_REGS_VH

`define T2CR_ADDR_CONTROL 8'hC8
`define T2CR_ADDR_RELOAD_LOW 8'hCA
`define T2CR_ADDR_RELOAD_HIGH 8'hCB
`define T2CR_ADDR_COUNT_LOW 8'hCC
`define T2CR_ADDR_COUNT_HIGH 8'hCD

`define T2CR_BIT_OVERFLOW_FLAG 7
`define T2CR_BIT_EXTERNAL_EVENT_FLAG 6
`define T2CR_BIT_RECEIVE_CLOCK_SELECT 5
`define T2CR_BIT_TRANSMIT_CLOCK_SELECT 4
`define T2CR_BIT_EXTERNAL_TRIGGER_ENABLE 3
`define T2CR_BIT_RUN_CONTROL 2
`define T2CR_BIT_FUNCTION_SELECT 1
`define T2CR_BIT_CAPTURE_SELECT 0

`define T2CR_RESET_CONTROL 8'h00
`define T2CR_RESET_BYTE 8'h00
`define T2CR_COUNT_ALL_ONES 16'hFFFF
`define T2CR_COUNT_ZERO 16'h0000

`define T2CR_SERIAL_MODE_1 2'h1
`define T2CR_SERIAL_MODE_3 2'h3

`endif

/* File: t2cr_fall_detect.v */
`timescale 1ns/10ps
`default_nettype none

module t2cr_fall_detect (
    input wire clk,
    input wire sys_rst,
    input wire pin_in,
    output reg fall_pulse
);

reg sync1_r;
reg sync2_r;
reg last_r;

// ----------------------------------------
// Two-stage synchroniser and edge detect
// ----------------------------------------
always @(posedge clk) begin
    if (sys_rst) begin
        sync1_r <= 1'b1;
        sync2_r <= 1'b1;
        last_r <= 1'b1;
        fall_pulse <= 1'b0;
    end else begin
        sync1_r <= pin_in;
        sync2_r <= sync1_r;
        last_r <= sync2_r;
        fall_pulse <= last_r & ~sync2_r;
    end
end

endmodule // t2cr_fall_detect
`default_nettype wire

/* File: t2cr_timer2.v */
`timescale 1ns/10ps
`default_nettype none
`include "t2cr_regs.vh"

module t2cr_timer2 (
    input wire clk,
    input wire sys_rst,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    output reg sfr_hit,
    input wire count_input_pin,
    input wire trigger_pin,
    input wire timer1_overflow,
    input wire [1:0] serial_mode,
    output reg serial_rx_tick,
    output reg serial_tx_tick,
    output reg overflow_pulse
);

reg [7:0] control_r;
reg [7:0] control_nxt;
reg [15:0] count_r;
reg [15:0] count_nxt;
reg [15:0] reload_r;
reg [15:0] reload_nxt;
reg [7:0] rdata_nxt;
reg hit_nxt;

wire count_fall;
wire trig_fall;

t2cr_fall_detect u_count_edge (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(count_input_pin),
    .fall_pulse(count_fall)
);

t2cr_fall_detect u_trig_edge (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(trigger_pin),
    .fall_pulse(trig_fall)
);

// ----------------------------------------
// Control decode
// ----------------------------------------
wire rx_sel = control_r[`T2CR_BIT_RECEIVE_CLOCK_SELECT];
wire tx_sel = control_r[`T2CR_BIT_TRANSMIT_CLOCK_SELECT];
wire trig_en = control_r[`T2CR_BIT_EXTERNAL_TRIGGER_ENABLE];
wire run = control_r[`T2CR_BIT_RUN_CONTROL];
wire func_sel = control_r[`T2CR_BIT_FUNCTION_SELECT];
wire cap_sel = control_r[`T2CR_BIT_CAPTURE_SELECT];
wire baud_use = rx_sel | tx_sel;
wire capture_mode = cap_sel & ~baud_use; // [R10]

// Counting tick
wire tick = run & (func_sel ? count_fall : 1'b1); // [R6] [R7]
wire ovf = tick & (count_r == `T2CR_COUNT_ALL_ONES); // [R13]
wire trig_event = trig_fall & trig_en & ~baud_use; // [R5]

// ----------------------------------------
// Decode functions
// ----------------------------------------
function wr_hit;
    input wr;
    input [7:0] addr;
    input [7:0] target;
    begin
        wr_hit = wr & (addr == target);
    end
endfunction

function baud_mode;
    input [1:0] mode;
    begin
        case (mode)
            `T2CR_SERIAL_MODE_1: baud_mode = 1'h1;
            `T2CR_SERIAL_MODE_3: baud_mode = 1'h1;
            default: baud_mode = 1'h0;
        endcase
    end
endfunction

wire serial_modes_13 = baud_mode(serial_mode);
wire wr_control = wr_hit(sfr_wr, sfr_addr, `T2CR_ADDR_CONTROL);
wire wr_count_low = wr_hit(sfr_wr, sfr_addr, `T2CR_ADDR_COUNT_LOW);
wire wr_count_high = wr_hit(sfr_wr, sfr_addr, `T2CR_ADDR_COUNT_HIGH);
wire wr_reload_low = wr_hit(sfr_wr, sfr_addr, `T2CR_ADDR_RELOAD_LOW);
wire wr_reload_high = wr_hit(sfr_wr, sfr_addr, `T2CR_ADDR_RELOAD_HIGH);

// ----------------------------------------
// Capture, reload and flag events
// ----------------------------------------
wire reload_on_ovf = ovf & ~capture_mode; // [R9] [R10]
wire reload_on_trig = trig_event & ~capture_mode; // [R9]
wire capture_on_trig = trig_event & capture_mode; // [R8]
wire do_reload = reload_on_ovf | reload_on_trig; // [R12]
wire set_ovf_flag = ovf & ~baud_use; // [R1]
wire set_ext_flag = trig_event; // [R2]

// ----------------------------------------
// Count next state
// ----------------------------------------
always @* begin
    count_nxt = count_r;
    if (tick) begin
        count_nxt = count_r + 16'h0001; // [R13]
    end
    if (do_reload) begin
        count_nxt = reload_r; // [R9] [R10] [R12]
    end
    if (wr_count_low) begin
        count_nxt[7:0] = sfr_wdata;
    end
    if (wr_count_high) begin
        count_nxt[15:8] = sfr_wdata;
    end
end

// ----------------------------------------
// Capture/reload pair next state
// ----------------------------------------
always @* begin
    reload_nxt = reload_r;
    if (capture_on_trig) begin
        reload_nxt = count_r; // [R8] [R12]
    end
    if (wr_reload_low) begin
        reload_nxt[7:0] = sfr_wdata;
    end
    if (wr_reload_high) begin
        reload_nxt[15:8] = sfr_wdata;
    end
end

// ----------------------------------------
// Control next state
// ----------------------------------------
always @* begin
    control_nxt = control_r;
    if (wr_control) begin
        control_nxt = sfr_wdata;
    end
    // Hardware set wins over a software clear
    if (set_ovf_flag) begin
        control_nxt[`T2CR_BIT_OVERFLOW_FLAG] = 1'h1; // [R1]
    end
    if (set_ext_flag) begin
        control_nxt[`T2CR_BIT_EXTERNAL_EVENT_FLAG] = 1'h1; // [R2]
    end
end

// ----------------------------------------
// Registers
// ----------------------------------------
always @(posedge clk) begin
    if (sys_rst) begin
        control_r <= `T2CR_RESET_CONTROL;
        count_r <= `T2CR_COUNT_ZERO; // [R11]
        reload_r <= `T2CR_COUNT_ZERO; // [R11]
    end else begin
        control_r <= control_nxt;
        count_r <= count_nxt;
        reload_r <= reload_nxt;
    end
end

// ----------------------------------------
// Serial baud ticks and overflow pulse
// ----------------------------------------
wire rx_src = rx_sel ? ovf : timer1_overflow; // [R3]
wire tx_src = tx_sel ? ovf : timer1_overflow; // [R4]

always @(posedge clk) begin
    if (sys_rst) begin
        serial_rx_tick <= 1'h0;
        serial_tx_tick <= 1'h0;
        overflow_pulse <= 1'h0;
    end else begin
        serial_rx_tick <= serial_modes_13 & rx_src; // [R3]
        serial_tx_tick <= serial_modes_13 & tx_src; // [R4]
        overflow_pulse <= ovf; // [R13]
    end
end

// ----------------------------------------
// Read mux, unmapped addresses read zero
// ----------------------------------------
always @* begin
    rdata_nxt = `T2CR_RESET_BYTE;
    hit_nxt = 1'h1;
    case (sfr_addr)
        `T2CR_ADDR_CONTROL: begin
            rdata_nxt = control_r;
        end
        `T2CR_ADDR_RELOAD_LOW: begin
            rdata_nxt = reload_r[7:0];
        end
        `T2CR_ADDR_RELOAD_HIGH: begin
            rdata_nxt = reload_r[15:8];
        end
        `T2CR_ADDR_COUNT_LOW: begin
            rdata_nxt = count_r[7:0];
        end
        `T2CR_ADDR_COUNT_HIGH: begin
            rdata_nxt = count_r[15:8];
        end
        default: begin
            hit_nxt = 1'h0;
        end
    endcase
end

// ----------------------------------------
// Read path, one cycle after the address
// ----------------------------------------
always @(posedge clk) begin
    if (sys_rst) begin
        sfr_rdata <= `T2CR_RESET_BYTE;
        sfr_hit <= 1'h0;
    end else begin
        sfr_rdata <= rdata_nxt;
        sfr_hit <= hit_nxt;
    end
end

endmodule // t2cr_timer2
`default_nettype wire

/* File: t2cr_chk_props.sv */
`timescale 1ns/10ps
`default_nettype none
module t2cr_chk (
    input wire clk,
    input wire sys_rst,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata,
    input wire sfr_hit,
    input wire timer1_overflow,
    input wire [1:0] serial_mode,
    input wire serial_rx_tick,
    input wire serial_tx_tick,
    input wire overflow_pulse
);
    // ----
    // Port relations
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    hit_map_a: assert property (!$past(sys_rst) |-> sfr_hit ==
        ($past(sfr_addr) inside {8'hC8, [8'hCA:8'hCD]})) else $error("hit");
    unmapped_zero_a: assert property (!sfr_hit |-> sfr_rdata == 8'h00)
        else $error("unmapped data");
    tick_mode_a: assert property ((serial_rx_tick || serial_tx_tick)
        |-> $past(serial_mode[0])) else $error("tick mode");
    rx_source_a: assert property (serial_rx_tick &&
        !$past(timer1_overflow) |-> overflow_pulse) else $error("rx tick");
    tx_source_a: assert property (serial_tx_tick &&
        !$past(timer1_overflow) |-> overflow_pulse) else $error("tx tick");
    ctrl_write_a: assert property (sfr_wr && sfr_addr == 8'hC8 ##1
        !sfr_wr && sfr_addr == 8'hC8 |=> sfr_rdata[5:0] ==
        $past(sfr_wdata[5:0], 2)) else $error("control bits");
    ovf_sticky_a: assert property ($past(sfr_addr) == 8'hC8 &&
        sfr_addr == 8'hC8 && sfr_rdata[7] && !sfr_wr && !$past(sfr_wr)
        |=> sfr_rdata[7]) else $error("overflow flag lost");
    ext_sticky_a: assert property ($past(sfr_addr) == 8'hC8 &&
        sfr_addr == 8'hC8 && sfr_rdata[6] && !sfr_wr && !$past(sfr_wr)
        |=> sfr_rdata[6]) else $error("event flag lost");
    cover property (overflow_pulse);
    cover property (serial_rx_tick && serial_tx_tick);
    cover property (sfr_wr && sfr_addr == 8'hC8);
endmodule // t2cr_chk
bind t2cr_timer2 t2cr_chk u_chk (.*);
`default_nettype wire

/* File: t2cr_pins.sv */
`timescale 1ns/10ps
`default_nettype none
module t2cr_pins (
    input wire logic clk,
    output logic count_input_pin,
    output logic trigger_pin
);
    // ----
    // Pin edges, each level held 3 clocks
    // ----
    initial {count_input_pin, trigger_pin} = 2'h3;
    task fall(input bit s);
        @(posedge clk);
        if (s) count_input_pin <= 1'h0;
        else trigger_pin <= 1'h0;
        repeat (3) @(posedge clk);
        {count_input_pin, trigger_pin} <= 2'h3;
        repeat (3) @(posedge clk);
    endtask
endmodule // t2cr_pins
`default_nettype wire

/* File: t2cr_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk, sys_rst, sfr_wr, got, t1_ovf;
    logic [7:0] sfr_addr, sfr_wdata;
    logic [1:0] serial_mode;
    wire [7:0] sfr_rdata;
    wire sfr_hit, cnt_pin, trg_pin, rx_tick, tx_tick, ovf;
    wire [1:0] ticks = {rx_tick, tx_tick};
    int n_mismatch, checked, i;
`define CK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h want %h", $time, a, e); end end
    // ----
    // Device and pins
    // ----
    t2cr_pins p (.clk(clk), .count_input_pin(cnt_pin), .trigger_pin(trg_pin));
    t2cr_timer2 i_dut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .count_input_pin(cnt_pin), .trigger_pin(trg_pin),
        .timer1_overflow(t1_ovf), .serial_mode(serial_mode),
        .serial_rx_tick(rx_tick), .serial_tx_tick(tx_tick),
        .overflow_pulse(ovf));
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk);
        {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'h1};
        @(posedge clk);
        sfr_wr <= 1'h0;
    endtask
    task rd(input [7:0] a, input [7:0] e);
        @(posedge clk);
        sfr_addr <= a;
        @(posedge clk);
        #1 `CK(sfr_rdata, e)
        `CK(sfr_hit, (a == 8'hC8 || (a >= 8'hCA && a <= 8'hCD)))
    endtask
    task t1_chk(input [1:0] m, input [1:0] e);
        @(posedge clk);
        {serial_mode, t1_ovf} <= {m, 1'h1};
        @(posedge clk);
        t1_ovf <= 1'h0;
        #1 `CK(ticks, e)
    endtask
    task report_and_stop;
        if (n_mismatch == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    initial begin
        #20000 n_mismatch++;
        report_and_stop;
    end
    // ----
    // Register sequences
    // ----
    initial begin
        {sys_rst, sfr_wr, sfr_addr, sfr_wdata, serial_mode} = {2'h2, 18'h1};
        t1_ovf = 1'h0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        for (i = 0; i < 6; i++) rd(8'hC8 + 8'(i), 8'h00);
        wr(8'hCC, 8'hFE);
        wr(8'hCD, 8'hFF);
        wr(8'hCA, 8'h34);
        wr(8'hCB, 8'h12);
        wr(8'hC8, 8'h04);
        repeat (3) @(posedge clk);
        rd(8'hC8, 8'h84);
        wr(8'hC8, 8'h00);
        rd(8'hCC, 8'h39);
        rd(8'hCD, 8'h12);
        wr(8'hC8, 8'h09);
        p.fall(0);
        repeat (4) @(posedge clk);
        rd(8'hCA, 8'h39);
        rd(8'hCB, 8'h12);
        rd(8'hC8, 8'h49);
        wr(8'hC8, 8'h08);
        wr(8'hCC, 8'h00);
        p.fall(0);
        repeat (4) @(posedge clk);
        rd(8'hCC, 8'h39);
        rd(8'hC8, 8'h48);
        wr(8'hC8, 8'h00);
        wr(8'hCC, 8'h11);
        p.fall(0);
        repeat (4) @(posedge clk);
        rd(8'hCC, 8'h11);
        rd(8'hC8, 8'h00);
        wr(8'hC8, 8'h18);
        p.fall(0);
        repeat (4) @(posedge clk);
        rd(8'hCC, 8'h11);
        rd(8'hC8, 8'h18);
        wr(8'hC8, 8'h06);
        repeat (3) p.fall(1);
        wr(8'hC8, 8'h00);
        rd(8'hCC, 8'h14);
        wr(8'hCC, 8'hFF);
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'h35);
        got = 1'h0;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            got = got | (rx_tick & tx_tick & ovf);
        end
        `CK(got, 1'h1)
        rd(8'hC8, 8'h35);
        wr(8'hC8, 8'h00);
        rd(8'hCC, 8'h44);
        rd(8'hCD, 8'h12);
        t1_chk(2'h1, 2'h3);
        t1_chk(2'h2, 2'h0);
        wr(8'hC8, 8'h20);
        t1_chk(2'h3, 2'h1);
        @(posedge clk) sys_rst <= 1'h1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        rd(8'hC8, 8'h00);
        rd(8'hCB, 8'h00);
        rd(8'hCD, 8'h00);
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
